//--- epd_pkg.sv
// Purpose: Shared constants for the encoder pulse divider.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Quadrature phase index runs 0..3 with A leading B when counting up.
package epd_pkg;

    // =========================================================================
    // Division ratio
    // =========================================================================
    localparam int          EPD_RATIO_W     = 15;
    localparam logic [14:0] EPD_RATIO_RESET = 15'h0001;
    localparam logic [14:0] EPD_RATIO_MIN   = 15'h0001;
    localparam logic [14:0] EPD_RATIO_MAX   = 15'h7FFF;

    // =========================================================================
    // Quadrature phase index and step codes
    // =========================================================================
    localparam int         EPD_IDX_W     = 2;
    localparam logic [1:0] EPD_IDX_RESET = 2'h0;
    localparam logic [1:0] EPD_STEP_NONE = 2'h0;
    localparam logic [1:0] EPD_STEP_FWD  = 2'h1;
    localparam logic [1:0] EPD_STEP_BAD  = 2'h2;
    localparam logic [1:0] EPD_STEP_REV  = 2'h3;

    // =========================================================================
    // Synchroniser
    // =========================================================================
    localparam int EPD_SYNC_STAGES = 2;

    typedef enum {
        EPD_DIR_FWD,
        EPD_DIR_REV
    } epd_dir_e;

endpackage

//--- epd_sync.sv
// Purpose: Two-flop synchroniser for the encoder input pins.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

module epd_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // =========================================================================
    // Stages
    // =========================================================================
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (clk_en) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

//--- epd_divider.sv
// Purpose: Divide encoder A/B quadrature by n and drive open-collector and
//          differential output groups; pass Z through undivided.
// Assumes: Encoder pins are asynchronous; ratio input is on sys_clk.
// Notes:   Division is done on quadrature states, so direction survives.
`timescale 1ns/1ps

module epd_divider
    import epd_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         clk_en,
    input  wire logic                         enc_phase_a,
    input  wire logic                         enc_phase_b,
    input  wire logic                         enc_phase_z,
    input  wire logic [epd_pkg::EPD_RATIO_W-1:0] pulse_division_ratio,
    input  wire logic                         ratio_load,
    output logic                              oc_phase_a_out,
    output logic                              oc_phase_a_oe,
    output logic                              oc_phase_b_out,
    output logic                              oc_phase_b_oe,
    output logic                              oc_phase_z_out,
    output logic                              oc_phase_z_oe,
    output logic                              diff_phase_a_out,
    output logic                              diff_phase_a_out_n,
    output logic                              diff_phase_b_out,
    output logic                              diff_phase_b_out_n,
    output logic                              diff_phase_z_out,
    output logic                              diff_phase_z_out_n,
    output logic                              rot_reverse,
    output logic                              enc_step_err
);

    import epd_pkg::*;

    // =========================================================================
    // Helpers
    // =========================================================================
    // Map an A/B level pair to a phase index that rises when A leads B.
    function automatic logic [EPD_IDX_W-1:0] quad_idx(input logic a, input logic b);
        quad_idx = {b, a ^ b};
    endfunction

    // A is high in phase indices 1 and 2.
    function automatic logic idx_phase_a(input logic [EPD_IDX_W-1:0] idx);
        idx_phase_a = idx[1] ^ idx[0];
    endfunction

    // B is high in phase indices 2 and 3.
    function automatic logic idx_phase_b(input logic [EPD_IDX_W-1:0] idx);
        idx_phase_b = idx[1];
    endfunction

    // =========================================================================
    // Pin synchronisation
    // =========================================================================
    logic [2:0] pins_sync;

    epd_sync #(
        .WIDTH (3)
    ) u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in ({enc_phase_z, enc_phase_b, enc_phase_a}),
        .sync_out (pins_sync)
    );

    wire in_a = pins_sync[0];
    wire in_b = pins_sync[1];
    wire in_z = pins_sync[2];

    // =========================================================================
    // Ratio setting
    // =========================================================================
    // A ratio of zero has no meaning, so it is taken as one rather than
    // stalling the outputs for good.
    logic [EPD_RATIO_W-1:0] ratio_r;
    logic [EPD_RATIO_W-1:0] ratio_nxt;
    wire                    ratio_zero = (pulse_division_ratio == '0);

    assign ratio_nxt = ratio_zero ? EPD_RATIO_MIN : pulse_division_ratio;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ratio_r <= EPD_RATIO_RESET;
        end else if (clk_en && ratio_load) begin
            ratio_r <= ratio_nxt;
        end
    end

    // =========================================================================
    // Input step decode
    // =========================================================================
    // Steps are trusted only once the synchroniser holds real pin levels.
    // Otherwise a pin left away from phase zero fakes a step after reset.
    logic [EPD_IDX_W-1:0] in_idx_r;
    logic                 idx_valid_r;
    logic [1:0]           fill_r;
    wire                  fill_done  = (fill_r == 2'(EPD_SYNC_STAGES));
    wire  [EPD_IDX_W-1:0] in_idx_now = quad_idx(in_a, in_b);
    wire  [EPD_IDX_W-1:0] step_raw   = in_idx_now - in_idx_r;
    wire  [EPD_IDX_W-1:0] step       = idx_valid_r ? step_raw : EPD_STEP_NONE;
    wire                  step_fwd   = (step == EPD_STEP_FWD);
    wire                  step_rev   = (step == EPD_STEP_REV);
    wire                  step_bad   = (step == EPD_STEP_BAD);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_idx_r    <= EPD_IDX_RESET;
            idx_valid_r <= 1'b0;
            fill_r      <= 2'h0;
        end else if (clk_en) begin
            in_idx_r    <= in_idx_now;
            idx_valid_r <= fill_done;
            if (!fill_done) begin
                fill_r <= fill_r + 2'h1;
            end
        end
    end

    // =========================================================================
    // Divider: one output phase step per n input phase steps
    // =========================================================================
    // Each output state lasts n input states, so high and low times both
    // scale by n and the duty cycle of the input is preserved.
    logic [EPD_RATIO_W-1:0] sub_r;
    logic [EPD_RATIO_W-1:0] sub_nxt;
    logic [EPD_IDX_W-1:0]   out_idx_r;
    logic [EPD_IDX_W-1:0]   out_idx_nxt;
    wire  [EPD_RATIO_W-1:0] ratio_top = ratio_r - EPD_RATIO_MIN;
    wire                    sub_at_top = (sub_r >= ratio_top);
    wire                    sub_at_bot = (sub_r == '0);

    always_comb begin
        sub_nxt     = sub_r;
        out_idx_nxt = out_idx_r;
        if (step_fwd) begin
            if (sub_at_top) begin
                sub_nxt     = '0;
                out_idx_nxt = out_idx_r + 2'h1;
            end else begin
                sub_nxt = sub_r + 15'h0001;
            end
        end else if (step_rev) begin
            if (sub_at_bot) begin
                sub_nxt     = ratio_top;
                out_idx_nxt = out_idx_r - 2'h1;
            end else if (sub_r > ratio_top) begin
                sub_nxt = ratio_top;
            end else begin
                sub_nxt = sub_r - 15'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sub_r     <= '0;
            out_idx_r <= EPD_IDX_RESET;
        end else if (clk_en) begin
            sub_r     <= sub_nxt;
            out_idx_r <= out_idx_nxt;
        end
    end

    // =========================================================================
    // Direction and fault flags
    // =========================================================================
    // A jump of two phase states means a missed edge; it is flagged and
    // otherwise ignored, since its direction cannot be known.
    epd_dir_e dir_r;
    logic     err_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dir_r <= EPD_DIR_FWD;
            err_r <= 1'b0;
        end else if (clk_en) begin
            err_r <= step_bad;
            case (1'b1)
                step_fwd: dir_r <= EPD_DIR_FWD;
                step_rev: dir_r <= EPD_DIR_REV;
                default:  dir_r <= dir_r;
            endcase
        end
    end

    assign rot_reverse  = (dir_r == EPD_DIR_REV);
    assign enc_step_err = err_r;

    // =========================================================================
    // Output registers
    // =========================================================================
    // A single set of registers feeds both groups, so the two groups can
    // never drift apart in ratio or phase.
    logic out_a_r;
    logic out_b_r;
    logic out_z_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            out_z_r <= 1'b0;
        end else if (clk_en) begin
            out_a_r <= idx_phase_a(out_idx_nxt);
            out_b_r <= idx_phase_b(out_idx_nxt);
            out_z_r <= in_z;
        end
    end

    // Open-collector pins pull low while the logical level is low.
    assign oc_phase_a_out = out_a_r;
    assign oc_phase_b_out = out_b_r;
    assign oc_phase_z_out = out_z_r;
    assign oc_phase_a_oe  = ~out_a_r;
    assign oc_phase_b_oe  = ~out_b_r;
    assign oc_phase_z_oe  = ~out_z_r;

    assign diff_phase_a_out   = out_a_r;
    assign diff_phase_a_out_n = ~out_a_r;
    assign diff_phase_b_out   = out_b_r;
    assign diff_phase_b_out_n = ~out_b_r;
    assign diff_phase_z_out   = out_z_r;
    assign diff_phase_z_out_n = ~out_z_r;

endmodule

//--- epd_divider_monitor.sv
// Purpose: Port checks for the encoder pulse divider.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Pin to output latency is three enabled edges.
`timescale 1ns/1ps
module epd_monitor
    import epd_pkg::*;
(
    input wire logic                    sys_clk,
    input wire logic                    sys_rst,
    input wire logic                    clk_en,
    input wire logic                    enc_phase_a,
    input wire logic                    enc_phase_b,
    input wire logic                    enc_phase_z,
    input wire logic [EPD_RATIO_W-1:0] pulse_division_ratio,
    input wire logic                    ratio_load,
    input wire logic                    oc_phase_a_out,
    input wire logic                    oc_phase_a_oe,
    input wire logic                    oc_phase_b_out,
    input wire logic                    oc_phase_b_oe,
    input wire logic                    oc_phase_z_out,
    input wire logic                    oc_phase_z_oe,
    input wire logic                    diff_phase_a_out,
    input wire logic                    diff_phase_a_out_n,
    input wire logic                    diff_phase_b_out,
    input wire logic                    diff_phase_b_out_n,
    input wire logic                    diff_phase_z_out,
    input wire logic                    diff_phase_z_out_n,
    input wire logic                    rot_reverse,
    input wire logic                    enc_step_err
);
    // ==========================================================
    // Checks
    // ==========================================================
    // Counts clean enabled edges, so pipeline checks skip frozen spans.
    logic [2:0] run_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !clk_en) begin
            run_r <= 3'h0;
        end else if (run_r != 3'h4) begin
            run_r <= run_r + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_primed;
        run_r >= 3'h3;
    endsequence
    sequence s_pins_still;
        run_r == 3'h4 && $past(enc_phase_a, 3) == $past(enc_phase_a, 4)
            && $past(enc_phase_b, 3) == $past(enc_phase_b, 4);
    endsequence
    AST_DIFF_COMP: assert property (diff_phase_a_out_n != diff_phase_a_out
        && diff_phase_b_out_n != diff_phase_b_out && diff_phase_z_out_n != diff_phase_z_out)
        else $error("complement line equals true line");
    AST_GRP_AB: assert property (oc_phase_a_out == diff_phase_a_out
        && oc_phase_b_out == diff_phase_b_out) else $error("output groups differ");
    AST_GRP_Z: assert property (oc_phase_z_out == diff_phase_z_out)
        else $error("z groups differ");
    AST_OC_OE: assert property (oc_phase_a_oe != oc_phase_a_out
        && oc_phase_b_oe != oc_phase_b_out && oc_phase_z_oe != oc_phase_z_out)
        else $error("open collector enable wrong");
    AST_RESET: assert property ($fell(sys_rst) |-> !(oc_phase_a_out | diff_phase_b_out
        | diff_phase_a_out | diff_phase_z_out | rot_reverse | enc_step_err))
        else $error("outputs not cleared by reset");
    AST_Z_PASS: assert property (s_primed |-> diff_phase_z_out == $past(enc_phase_z, 3))
        else $error("z not passed through");
    AST_HOLD: assert property (s_pins_still |-> $stable(diff_phase_a_out)
        && $stable(diff_phase_b_out)) else $error("output moved without input step");
    AST_ONE_STEP: assert property (!($changed(diff_phase_a_out)
        && $changed(diff_phase_b_out))) else $error("a and b changed together");
endmodule
bind epd_divider epd_monitor u_mon (.sys_clk, .sys_rst, .clk_en, .enc_phase_a, .enc_phase_b,
    .enc_phase_z, .pulse_division_ratio, .ratio_load, .oc_phase_a_out, .oc_phase_a_oe,
    .oc_phase_b_out, .oc_phase_b_oe, .oc_phase_z_out, .oc_phase_z_oe, .diff_phase_a_out,
    .diff_phase_a_out_n, .diff_phase_b_out, .diff_phase_b_out_n, .diff_phase_z_out,
    .diff_phase_z_out_n, .rot_reverse, .enc_step_err);

//--- epd_quad_rx.sv
// Purpose: Counter standing where the divided outputs are received.
// Assumes: Its inputs move at most one quadrature state per clock.
// Notes:   Counts four per output cycle; a two-state jump is not counted.
`timescale 1ns/1ps
module epd_quad_rx (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    output logic      [15:0] pos
);
    // ==========================================================
    // Decoder
    // ==========================================================
    logic [1:0] st_r;
    wire  [1:0] st    = {phase_b, phase_a ^ phase_b};
    wire  [1:0] delta = st - st_r;
    always_ff @(posedge sys_clk) begin
        st_r <= st;
        if (sys_rst) begin
            pos <= 16'h0000;
        end else if (delta == 2'h1) begin
            pos <= pos + 16'h0001;
        end else if (delta == 2'h3) begin
            pos <= pos - 16'h0001;
        end
    end
endmodule

//--- tb_encoder_pulse_divider.sv
// Purpose: Self-checking bench for the encoder pulse divider.
// Assumes: Inputs change on the falling edge.
// Notes:   Each input step is held five cycles to clear the synchroniser.
`timescale 1ns/1ps
module tb_encoder_pulse_divider;
    import epd_pkg::*;
    // ==========================================================
    // Stimulus and scenarios
    // ==========================================================
    logic sys_clk = 0, sys_rst = 1, clk_en = 1, ratio_load = 0;
    logic enc_phase_a = 0, enc_phase_b = 0, enc_phase_z = 0;
    logic [14:0] pulse_division_ratio = 15'h0001;
    logic [1:0]  q = 2'h0;
    logic [15:0] pos, p;
    logic oc_phase_a_out, oc_phase_a_oe, oc_phase_b_out, oc_phase_b_oe;
    logic oc_phase_z_out, oc_phase_z_oe, diff_phase_a_out, diff_phase_a_out_n;
    logic diff_phase_b_out, diff_phase_b_out_n, diff_phase_z_out, diff_phase_z_out_n;
    logic rot_reverse, enc_step_err;
    int mismatches = 0, cmp_count = 0, cycles = 0, hi_cnt = 0, hi_w = 0;
    always #4 sys_clk = ~sys_clk;
    epd_divider dut (.sys_clk, .sys_rst, .clk_en, .enc_phase_a, .enc_phase_b,
        .enc_phase_z, .pulse_division_ratio, .ratio_load, .oc_phase_a_out, .oc_phase_a_oe,
        .oc_phase_b_out, .oc_phase_b_oe, .oc_phase_z_out, .oc_phase_z_oe, .diff_phase_a_out,
        .diff_phase_a_out_n, .diff_phase_b_out, .diff_phase_b_out_n, .diff_phase_z_out,
        .diff_phase_z_out_n, .rot_reverse, .enc_step_err);
    epd_quad_rx rx (.sys_clk, .sys_rst, .phase_a(diff_phase_a_out),
        .phase_b(diff_phase_b_out), .pos);
    task automatic summarize;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // High time of output A in cycles; the ceiling cuts a hang short.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        hi_cnt <= diff_phase_a_out ? hi_cnt + 1 : 0;
        if (!diff_phase_a_out && hi_cnt != 0) begin
            hi_w <= hi_cnt;
        end
        if (cycles == 2000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input bit fwd, input int k);
        repeat (k) begin
            @(negedge sys_clk);
            q = fwd ? q + 2'h1 : q - 2'h1;
            enc_phase_a = q[0] ^ q[1];
            enc_phase_b = q[1];
            repeat (4) @(negedge sys_clk);
        end
    endtask
    task automatic load(input logic [14:0] n);
        @(negedge sys_clk);
        pulse_division_ratio = n;
        ratio_load = 1;
        @(negedge sys_clk);
        ratio_load = 0;
    endtask
    task automatic t_reset;
        chk({diff_phase_a_out_n, diff_phase_b_out_n, oc_phase_a_oe, oc_phase_b_oe}, 4'hF);
        chk({diff_phase_a_out, oc_phase_b_out, rot_reverse}, 3'h0);
    endtask
    task automatic t_ratio_one;
        p = pos;
        step(1, 8);
        chk(pos, p + 16'h0008);
        chk(diff_phase_a_out, enc_phase_a);
    endtask
    task automatic t_ratio_three;
        load(15'h0003);
        p = pos;
        step(1, 12);
        chk(pos, p + 16'h0004);
        chk(rot_reverse, 1'b0);
        step(0, 12);
        chk(pos, p);
        chk(rot_reverse, 1'b1);
    endtask
    task automatic t_z_pass;
        @(negedge sys_clk);
        enc_phase_z = 1;
        repeat (3) @(negedge sys_clk);
        chk({diff_phase_z_out, diff_phase_z_out_n, oc_phase_z_out, oc_phase_z_oe}, 4'hA);
        enc_phase_z = 0;
        repeat (3) @(negedge sys_clk);
        chk({diff_phase_z_out, diff_phase_z_out_n, oc_phase_z_out, oc_phase_z_oe}, 4'h5);
    endtask
    task automatic t_duty;
        load(15'h0002);
        step(1, 16);
        chk(hi_w, 20);
    endtask
    task automatic t_max;
        load(15'h7FFF);
        p = pos;
        step(1, 8);
        chk(pos, p);
    endtask
    task automatic t_bad_step;
        p = pos;
        @(negedge sys_clk);
        q = q + 2'h2;
        enc_phase_a = q[0] ^ q[1];
        enc_phase_b = q[1];
        repeat (3) @(negedge sys_clk);
        chk(enc_step_err, 1'b1);
        @(negedge sys_clk);
        chk(enc_step_err, 1'b0);
        repeat (3) @(negedge sys_clk);
        chk(pos, p);
    endtask
    task automatic t_freeze;
        @(negedge sys_clk);
        clk_en = 0;
        enc_phase_z = 1;
        repeat (5) @(negedge sys_clk);
        chk(diff_phase_z_out, 1'b0);
        clk_en = 1;
        repeat (3) @(negedge sys_clk);
        chk(diff_phase_z_out, 1'b1);
        enc_phase_z = 0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic t_reset_again;
        step(1, 1);
        @(negedge sys_clk);
        sys_rst = 1;
        repeat (3) @(negedge sys_clk);
        sys_rst = 0;
        chk({diff_phase_a_out, diff_phase_b_out, enc_step_err}, 3'h0);
        p = pos;
        step(1, 4);
        chk(pos, p + 16'h0004);
        chk(rot_reverse, 1'b0);
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 0;
        t_reset();
        t_ratio_one();
        t_ratio_three();
        t_z_pass();
        t_duty();
        t_max();
        t_bad_step();
        t_freeze();
        t_reset_again();
        summarize();
    end
endmodule
